//--- hdl/flash_host_pkg.sv
package flash_host_pkg;

  localparam int CLK_MHZ = 125;
  localparam int CLK_PERIOD_NS = 8;

  localparam int ADDR_W = 19;
  localparam int SECTOR_SHIFT = 16;
  localparam int SECTOR_BITS = ADDR_W - SECTOR_SHIFT;

  // word addresses of the unlock cycles
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_A = 19'h00555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_B = 19'h002AA;

  localparam logic [15:0] D_UNLOCK_A = 16'h00AA;
  localparam logic [15:0] D_UNLOCK_B = 16'h0055;
  localparam logic [15:0] D_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] D_SECTOR_ERASE = 16'h0030;
  localparam logic [15:0] D_CHIP_ERASE = 16'h0010;
  localparam logic [15:0] D_PROGRAM = 16'h00A0;
  localparam logic [15:0] D_SUSPEND = 16'h00B0;
  localparam logic [15:0] D_RESUME = 16'h0030;
  localparam logic [15:0] D_RESET = 16'h00F0;
  localparam logic [15:0] D_ID_ENTRY = 16'h0090;
  localparam logic [15:0] D_BYPASS_EXIT_A = 16'h0090;
  localparam logic [15:0] D_BYPASS_EXIT_B = 16'h0000;

  localparam int DATA_POLL_BIT = 7;
  localparam int PRIMARY_TOGGLE_BIT = 6;
  localparam int SECONDARY_TOGGLE_BIT = 2;

  // worst-case suspend latency of the flash
  localparam int ERASE_SUSP_MAX_US = 20;
  localparam int PROG_SUSP_MAX_US = 15;
  localparam int ERASE_SUSP_CYC = ERASE_SUSP_MAX_US * CLK_MHZ;
  localparam int PROG_SUSP_CYC = PROG_SUSP_MAX_US * CLK_MHZ;

  localparam int ACCEL_MAX_USES = 10;

  // bus cycle shape, least times rounded up to whole cycles
  localparam int BUS_SETUP_NS = 16;
  localparam int WE_PULSE_NS = 32;
  localparam int BUS_HOLD_NS = 16;
  localparam int READ_ACCESS_NS = 96;
  localparam int SETUP_CYC = (BUS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (BUS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    OP_READ, OP_POLL, OP_SECTOR_ERASE, OP_CHIP_ERASE, OP_PROGRAM, OP_SUSPEND,
    OP_RESUME, OP_ID_ENTER, OP_RESET, OP_ACCEL_ON, OP_ACCEL_OFF, OP_BYPASS_EXIT
  } op_t;

  typedef enum logic [2:0] {
    M_READY, M_ERASING, M_CHIP_ERASE, M_ERASE_SUSP, M_PROG, M_PROG_IN_ESUSP,
    M_PROG_SUSP, M_PROG_SUSP_ES
  } mode_t;

endpackage

//--- hdl/flash_bus_cycle.sv
module flash_bus_cycle
  import flash_host_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic readNotWrite,
  input wire logic [ADDR_W-1:0] addrIn,
  input wire logic [15:0] dataIn,
  output logic idle,
  output logic done,
  output logic [15:0] rdData,
  output logic [ADDR_W-1:0] flashAddr,
  output logic [15:0] dqOut,
  input wire logic [15:0] dqIn,
  output logic dqDrvN,
  output logic ceN,
  output logic oeN,
  output logic weN
);

  typedef enum logic [1:0] {B_IDLE, B_SETUP, B_STROBE, B_HOLD} phase_t;

  phase_t phase_r;
  logic [3:0] cnt_r;
  logic rd_r;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_r <= B_IDLE;
      cnt_r <= 4'h0;
      rd_r <= 1'b0;
      flashAddr <= '0;
      dqOut <= 16'h0000;
      rdData <= 16'h0000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (phase_r)
        B_IDLE: begin
          if (start) begin
            rd_r <= readNotWrite;
            flashAddr <= addrIn;
            dqOut <= dataIn;
            phase_r <= B_SETUP;
            cnt_r <= readNotWrite ? 4'(READ_CYC - 1) : 4'(SETUP_CYC - 1);
          end
        end
        B_SETUP: begin
          if (cnt_r == 4'h0) begin
            if (rd_r) begin
              rdData <= dqIn;
              phase_r <= B_HOLD;
              cnt_r <= 4'(HOLD_CYC - 1);
            end else begin
              phase_r <= B_STROBE;
              cnt_r <= 4'(PULSE_CYC - 1);
            end
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        B_STROBE: begin
          if (cnt_r == 4'h0) begin
            phase_r <= B_HOLD;
            cnt_r <= 4'(HOLD_CYC - 1);
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        B_HOLD: begin
          if (cnt_r == 4'h0) begin
            phase_r <= B_IDLE;
            done <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        default: phase_r <= B_IDLE;
      endcase
    end
  end

  assign idle = (phase_r == B_IDLE);
  assign ceN = (phase_r == B_IDLE);
  assign oeN = !(rd_r && phase_r == B_SETUP);
  assign weN = (phase_r != B_STROBE);
  assign dqDrvN = !(!rd_r && phase_r != B_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  a_we_pulse_width: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $fell(weN) |-> (!weN)[*4] ##1 weN)
    else $error("write strobe width wrong");

  a_read_to_done: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $fell(oeN) |-> ##14 done)
    else $error("read cycle length wrong");

  a_strobe_excl: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !weN |-> (oeN && !dqDrvN && !ceN))
    else $error("write strobe without data drive");

endmodule

//--- hdl/flash_suspend_ctrl.sv
module flash_suspend_ctrl
  import flash_host_pkg::*;
#(
  parameter int ACCEL_USES = ACCEL_MAX_USES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic cmdValid,
  input op_t cmdOp,
  input wire logic [ADDR_W-1:0] cmdAddr,
  input wire logic [15:0] cmdData,
  input wire logic sectorUnlocked,
  output logic cmdReady,
  output logic rspValid,
  output logic rspRefused,
  output logic rspOpDone,
  output logic [15:0] rspData,
  output mode_t deviceMode,
  output logic protectAccelHigh,
  output logic [ADDR_W-1:0] flashAddr,
  output logic [15:0] dqOut,
  input wire logic [15:0] dqIn,
  output logic dqDrvN,
  output logic ceN,
  output logic oeN,
  output logic weN
);

  localparam int NUM_SECTORS = 1 << SECTOR_BITS;
  localparam int USE_W = $clog2(ACCEL_USES + 1);

  typedef enum logic [2:0] {S_IDLE, S_WRITE, S_SUSP_WAIT, S_READ_A, S_READ_B} state_t;

  state_t state_r;
  mode_t mode_r;
  op_t opLat_r;
  logic [ADDR_W-1:0] addrLat_r;
  logic [15:0] dataLat_r;
  logic [2:0] idx_r;
  logic issued_r;
  logic accel_r;
  logic [11:0] waitCnt_r;
  logic [15:0] firstRead_r;
  logic [SECTOR_BITS-1:0] eraseSector_r;
  logic [SECTOR_BITS-1:0] progSector_r;
  logic [USE_W-1:0] accelUses_r [NUM_SECTORS];
  logic busIdle;
  logic busDone;
  logic busStart;
  logic [15:0] busRdData;
  logic [ADDR_W-1:0] busAddr;
  logic [15:0] busData;
  logic accept;
  logic allowed;
  logic lastWord;
  logic writeEnd;
  logic waitEnd;
  logic pollEnd;
  logic [SECTOR_BITS-1:0] cmdSector;

  function automatic logic [SECTOR_BITS-1:0] sectorOf(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:SECTOR_SHIFT];
  endfunction

  function automatic logic [2:0] seqLen(input op_t op, input logic accel);
    case (op)
      OP_SECTOR_ERASE, OP_CHIP_ERASE: seqLen = 3'h6;
      OP_PROGRAM: seqLen = accel ? 3'h2 : 3'h4;
      OP_ID_ENTER, OP_RESET: seqLen = 3'h3;
      OP_BYPASS_EXIT: seqLen = 3'h2;
      OP_SUSPEND, OP_RESUME: seqLen = 3'h1;
      default: seqLen = 3'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  assign cmdReady = (state_r == S_IDLE);
  assign accept = cmdValid && cmdReady;
  assign cmdSector = sectorOf(cmdAddr);
  assign lastWord = (idx_r == seqLen(opLat_r, accel_r) - 3'h1);
  assign writeEnd = (state_r == S_WRITE) && busDone && lastWord;
  assign waitEnd = (state_r == S_SUSP_WAIT) && (waitCnt_r == 12'h000);
  assign pollEnd = (state_r == S_READ_B) && busDone;
  assign busStart = (state_r inside {S_WRITE, S_READ_A, S_READ_B}) && busIdle && !issued_r;
  assign deviceMode = mode_r;
  assign protectAccelHigh = accel_r;

  always_comb begin
    allowed = 1'b0;
    case (cmdOp)
      OP_READ: allowed = (mode_r == M_READY) ||
        (mode_r == M_ERASE_SUSP && cmdSector != eraseSector_r) ||
        (mode_r == M_PROG_SUSP && cmdSector != progSector_r) ||
        (mode_r == M_PROG_SUSP_ES && cmdSector != eraseSector_r && cmdSector != progSector_r);
      OP_POLL: allowed = mode_r inside {M_ERASING, M_CHIP_ERASE, M_PROG,
        M_PROG_IN_ESUSP, M_ERASE_SUSP};
      OP_SECTOR_ERASE, OP_CHIP_ERASE: allowed = (mode_r == M_READY) && !accel_r;
      OP_PROGRAM: allowed = (mode_r == M_READY &&
        (!accel_r || accelUses_r[cmdSector] < USE_W'(ACCEL_USES))) ||
        (mode_r == M_ERASE_SUSP && cmdSector != eraseSector_r && !accel_r);
      OP_SUSPEND: allowed = mode_r inside {M_ERASING, M_PROG, M_PROG_IN_ESUSP};
      OP_RESUME: allowed = mode_r inside {M_ERASE_SUSP, M_PROG_SUSP, M_PROG_SUSP_ES};
      OP_ID_ENTER: allowed = !accel_r && (mode_r inside
        {M_READY, M_ERASE_SUSP, M_PROG_SUSP, M_PROG_SUSP_ES});
      OP_RESET: allowed = (mode_r inside {M_READY, M_ERASE_SUSP, M_PROG_SUSP, M_PROG_SUSP_ES}) ||
        (accel_r && mode_r == M_PROG);
      OP_ACCEL_ON: allowed = (mode_r == M_READY) && !accel_r && sectorUnlocked;
      OP_ACCEL_OFF: allowed = (mode_r == M_READY) && accel_r;
      OP_BYPASS_EXIT: allowed = (mode_r == M_READY) && !accel_r;
      default: allowed = 1'b0;
    endcase
  end

  // word issued for the current step of a command sequence
  always_comb begin
    busAddr = addrLat_r;
    busData = dataLat_r;
    case (opLat_r)
      OP_SECTOR_ERASE, OP_CHIP_ERASE, OP_PROGRAM, OP_ID_ENTER, OP_RESET: begin
        if (opLat_r == OP_PROGRAM && accel_r) begin
          busData = (idx_r == 3'h0) ? D_PROGRAM : dataLat_r;
        end else if (idx_r == 3'h0 || idx_r == 3'h3 && opLat_r != OP_PROGRAM) begin
          busAddr = UNLOCK_ADDR_A;
          busData = D_UNLOCK_A;
        end else if (idx_r == 3'h1 || idx_r == 3'h4) begin
          busAddr = UNLOCK_ADDR_B;
          busData = D_UNLOCK_B;
        end else if (!lastWord) begin
          busAddr = UNLOCK_ADDR_A;
          busData = (opLat_r == OP_PROGRAM) ? D_PROGRAM : D_ERASE_SETUP;
        end else if (opLat_r == OP_SECTOR_ERASE) begin
          busData = D_SECTOR_ERASE;
        end else if (opLat_r == OP_CHIP_ERASE) begin
          busAddr = UNLOCK_ADDR_A;
          busData = D_CHIP_ERASE;
        end else if (opLat_r == OP_ID_ENTER) begin
          busAddr = UNLOCK_ADDR_A;
          busData = D_ID_ENTRY;
        end else if (opLat_r == OP_RESET) begin
          busData = D_RESET;
        end
      end
      OP_BYPASS_EXIT: busData = (idx_r == 3'h0) ? D_BYPASS_EXIT_A : D_BYPASS_EXIT_B;
      OP_SUSPEND: busData = D_SUSPEND;
      OP_RESUME: busData = D_RESUME;
      default: busData = dataLat_r;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= S_IDLE;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (accept && allowed) begin
            if (cmdOp == OP_READ || cmdOp == OP_POLL) begin
              state_r <= S_READ_A;
            end else if (seqLen(cmdOp, accel_r) != 3'h0) begin
              state_r <= S_WRITE;
            end
          end
        end
        S_WRITE: if (writeEnd) state_r <= (opLat_r == OP_SUSPEND) ? S_SUSP_WAIT : S_IDLE;
        S_SUSP_WAIT: if (waitEnd) state_r <= S_IDLE;
        S_READ_A: if (busDone) state_r <= (opLat_r == OP_POLL) ? S_READ_B : S_IDLE;
        S_READ_B: if (busDone) state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      opLat_r <= OP_READ;
      addrLat_r <= '0;
      dataLat_r <= 16'h0000;
      idx_r <= 3'h0;
      issued_r <= 1'b0;
      firstRead_r <= 16'h0000;
    end else begin
      if (accept) begin
        opLat_r <= cmdOp;
        addrLat_r <= cmdAddr;
        dataLat_r <= cmdData;
        idx_r <= 3'h0;
      end else if (state_r == S_WRITE && busDone) begin
        idx_r <= idx_r + 3'h1;
      end
      if (busStart) begin
        issued_r <= 1'b1;
      end else if (busDone) begin
        issued_r <= 1'b0;
      end
      if (state_r == S_READ_A && busDone) begin
        firstRead_r <= busRdData;
      end
    end
  end

  // host waits out the worst-case suspend latency; inside the sector-select
  // window the flash suspends at once, so the full wait is merely safe there
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      waitCnt_r <= 12'h000;
    end else if (writeEnd && opLat_r == OP_SUSPEND) begin
      waitCnt_r <= (mode_r == M_ERASING) ? 12'(ERASE_SUSP_CYC - 1)
                                         : 12'(PROG_SUSP_CYC - 1);
    end else if (state_r == S_SUSP_WAIT && waitCnt_r != 12'h000) begin
      waitCnt_r <= waitCnt_r - 12'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= M_READY;
      eraseSector_r <= '0;
      progSector_r <= '0;
    end else begin
      if (accept && allowed && cmdOp == OP_SECTOR_ERASE) eraseSector_r <= cmdSector;
      if (accept && allowed && cmdOp == OP_PROGRAM) progSector_r <= cmdSector;
      if (writeEnd) begin
        case (opLat_r)
          OP_SECTOR_ERASE: mode_r <= M_ERASING;
          OP_CHIP_ERASE: mode_r <= M_CHIP_ERASE;
          OP_PROGRAM: mode_r <= (mode_r == M_ERASE_SUSP) ? M_PROG_IN_ESUSP : M_PROG;
          OP_RESUME: begin
            case (mode_r)
              M_ERASE_SUSP: mode_r <= M_ERASING;
              M_PROG_SUSP: mode_r <= M_PROG;
              M_PROG_SUSP_ES: mode_r <= M_PROG_IN_ESUSP;
              default: mode_r <= mode_r;
            endcase
          end
          OP_RESET: if (mode_r == M_PROG) mode_r <= M_READY;
          default: mode_r <= mode_r;
        endcase
      end else if (waitEnd) begin
        case (mode_r)
          M_ERASING: mode_r <= M_ERASE_SUSP;
          M_PROG: mode_r <= M_PROG_SUSP;
          M_PROG_IN_ESUSP: mode_r <= M_PROG_SUSP_ES;
          default: mode_r <= mode_r;
        endcase
      end else if (pollEnd &&
                   firstRead_r[PRIMARY_TOGGLE_BIT] == busRdData[PRIMARY_TOGGLE_BIT]) begin
        case (mode_r)
          M_ERASING, M_CHIP_ERASE, M_PROG: mode_r <= M_READY;
          M_PROG_IN_ESUSP: mode_r <= M_ERASE_SUSP;
          default: mode_r <= mode_r;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      accel_r <= 1'b0;
    end else if (accept && allowed && cmdOp == OP_ACCEL_ON) begin
      accel_r <= 1'b1;
    end else if (accept && allowed && cmdOp == OP_ACCEL_OFF) begin
      accel_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_SECTORS; i++) accelUses_r[i] <= '0;
    end else if (accept && allowed && cmdOp == OP_PROGRAM && accel_r) begin
      accelUses_r[cmdSector] <= accelUses_r[cmdSector] + USE_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rspValid <= 1'b0;
      rspRefused <= 1'b0;
      rspOpDone <= 1'b0;
      rspData <= 16'h0000;
    end else begin
      rspValid <= 1'b0;
      if (accept && !allowed) begin
        rspValid <= 1'b1;
        rspRefused <= 1'b1;
        rspOpDone <= 1'b0;
      end else if (accept && (cmdOp == OP_ACCEL_ON || cmdOp == OP_ACCEL_OFF)) begin
        rspValid <= 1'b1;
        rspRefused <= 1'b0;
        rspOpDone <= 1'b0;
      end else if ((writeEnd && opLat_r != OP_SUSPEND) || waitEnd ||
                   (state_r == S_READ_A && busDone && opLat_r == OP_READ)) begin
        rspValid <= 1'b1;
        rspRefused <= 1'b0;
        rspOpDone <= 1'b0;
        if (state_r == S_READ_A) rspData <= busRdData;
      end else if (pollEnd) begin
        rspValid <= 1'b1;
        rspRefused <= 1'b0;
        rspData <= busRdData;
        rspOpDone <= (firstRead_r[PRIMARY_TOGGLE_BIT] == busRdData[PRIMARY_TOGGLE_BIT]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  flash_bus_cycle u_bus (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .start(busStart),
    .readNotWrite(state_r != S_WRITE),
    .addrIn(busAddr),
    .dataIn(busData),
    .idle(busIdle),
    .done(busDone),
    .rdData(busRdData),
    .flashAddr(flashAddr),
    .dqOut(dqOut),
    .dqIn(dqIn),
    .dqDrvN(dqDrvN),
    .ceN(ceN),
    .oeN(oeN),
    .weN(weN)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_chip_no_suspend: assert property (
    accept && cmdOp == OP_SUSPEND && mode_r == M_CHIP_ERASE |-> ##1 rspValid && rspRefused)
    else $error("suspend during chip erase not refused");
  a_erase_susp_wait: assert property (
    $changed(mode_r) && mode_r == M_ERASE_SUSP && $past(mode_r) == M_ERASING
    |-> $past(state_r) == S_SUSP_WAIT && $past(waitCnt_r) == 12'h000)
    else $error("erase suspended before latency elapsed");
  a_suspend_active: assert property (
    busStart && state_r == S_WRITE && opLat_r == OP_SUSPEND
    |-> mode_r inside {M_ERASING, M_PROG, M_PROG_IN_ESUSP})
    else $error("suspend issued with nothing running");
  a_resume_ignored: assert property (
    accept && cmdOp == OP_RESUME && !(mode_r inside {M_ERASE_SUSP, M_PROG_SUSP, M_PROG_SUSP_ES})
    |-> ##1 rspRefused && mode_r == $past(mode_r))
    else $error("stray resume not refused");
  a_accel_unlock: assert property (
    $rose(protectAccelHigh) |-> $past(sectorUnlocked) && $past(mode_r) == M_READY)
    else $error("accelerate raised without unlocked sectors");
  a_accel_off_idle: assert property (
    $fell(protectAccelHigh) |-> $past(mode_r) == M_READY)
    else $error("accelerate removed while programming");
  a_accel_limit: assert property (
    accelUses_r[cmdSector] <= USE_W'(ACCEL_USES))
    else $error("accelerated program limit exceeded");
  a_reset_three: assert property (
    busDone && state_r == S_WRITE && opLat_r == OP_RESET |-> ##1 rspValid == ($past(idx_r) == 3'h2))
    else $error("reset sequence not three cycles");
  a_prog_return: assert property (
    rspValid && rspOpDone && $past(mode_r) == M_PROG_IN_ESUSP |-> mode_r == M_ERASE_SUSP)
    else $error("program in erase suspend did not return");
  a_bypass_exit: assert property (
    busDone && state_r == S_WRITE && opLat_r == OP_BYPASS_EXIT && idx_r == 3'h0
    |-> ##[1:4] busStart && busData == D_BYPASS_EXIT_B)
    else $error("bypass exit second cycle missing");

endmodule

//--- bench/flash_device_model.sv
module flash_device_model
  import flash_host_pkg::*;
#(
  parameter int DONE_N = 3,
  parameter logic [15:0] ID_CODE = 16'h1234 // arbitrary value
) (
  input wire logic [ADDR_W-1:0] flashAddr,
  input wire logic [15:0] dqOut,
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  output logic [15:0] dqIn
);
  // es: 0 idle, 1 erasing, 2 suspended, 3 chip erase; ps: 0 idle, 1 busy, 2 suspended
  logic [1:0] es = 2'h0;
  logic [1:0] ps = 2'h0;
  logic progNext = 1'b0;
  logic idm = 1'b0;
  logic tog = 1'b0;
  logic t2 = 1'b0;
  logic [SECTOR_BITS-1:0] eSec = '0;
  logic [15:0] prev = 16'h0000;
  logic [15:0] rd = 16'h0000;
  int cnt = 0;
  // released bus shows the inverse of the last word
  assign dqIn = (!ceN && !oeN) ? rd : ~rd;
  ////////////////////////////////////////
  always @(posedge weN) begin
    if (!ceN) begin
      if (progNext) begin
        progNext = 1'b0;
        ps = 2'h1;
        cnt = 0;
      end else if (dqOut == D_SUSPEND) begin
        if (ps == 2'h1) ps = 2'h2;
        else if (es == 2'h1) es = 2'h2;
      end else if (dqOut == D_SECTOR_ERASE && prev == D_UNLOCK_B) begin
        es = 2'h1;
        eSec = flashAddr[ADDR_W-1:SECTOR_SHIFT];
        cnt = 0;
      end else if (dqOut == D_RESUME) begin
        if (ps == 2'h2) ps = 2'h1;
        else if (es == 2'h2 && ps == 2'h0) es = 2'h1;
      end else if (dqOut == D_CHIP_ERASE && prev == D_UNLOCK_B) begin
        es = 2'h3;
        cnt = 0;
      end else if (dqOut == D_PROGRAM) progNext = 1'b1;
      else if (dqOut == D_ID_ENTRY && prev == D_UNLOCK_B) idm = 1'b1;
      else if (dqOut == D_RESET) idm = 1'b0;
      prev = dqOut;
    end
  end
  always @(negedge oeN) begin
    if (!ceN) begin
      if (idm) rd = ID_CODE;
      else if (es[0] || ps == 2'h1) begin
        tog = ~tog;
        rd = {8'h00, 1'b0, tog, 3'h0, tog, 2'h0};
        cnt++;
        if (cnt >= DONE_N && ps == 2'h1) ps = 2'h0;
        else if (cnt >= DONE_N) es = 2'h0;
      end else if (es == 2'h2 && flashAddr[ADDR_W-1:SECTOR_SHIFT] == eSec) begin
        t2 = ~t2;
        rd = {8'h00, 1'b1, tog, 3'h0, t2, 2'h0};
      end else rd = flashAddr[15:0] ^ 16'h5A5A;
    end
  end
endmodule

//--- bench/flash_suspend_resume_control_bench.sv
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end

module flash_suspend_resume_control_bench import flash_host_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmdValid = 1'b0;
  logic sectorUnlocked = 1'b0;
  op_t cmdOp = OP_READ;
  logic [ADDR_W-1:0] cmdAddr = '0;
  logic [15:0] cmdData = 16'h0000;
  logic cmdReady, rspValid, rspRefused, rspOpDone, protectAccelHigh, dqDrvN, ceN, oeN, weN;
  logic [15:0] rspData, dqOut, dqIn;
  logic [ADDR_W-1:0] flashAddr;
  mode_t deviceMode;
  int n_mismatch = 0;
  int checks = 0;
  int lastWait = 0;

  flash_suspend_ctrl #(.ACCEL_USES(2)) dut_u (.ref_clk(ref_clk), .arst_n(arst_n),
    .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData),
    .sectorUnlocked(sectorUnlocked), .cmdReady(cmdReady), .rspValid(rspValid),
    .rspRefused(rspRefused), .rspOpDone(rspOpDone), .rspData(rspData),
    .deviceMode(deviceMode), .protectAccelHigh(protectAccelHigh), .flashAddr(flashAddr),
    .dqOut(dqOut), .dqIn(dqIn), .dqDrvN(dqDrvN), .ceN(ceN), .oeN(oeN), .weN(weN));
  flash_device_model mdl_u (.flashAddr(flashAddr), .dqOut(dqOut), .ceN(ceN), .oeN(oeN),
    .weN(weN), .dqIn(dqIn));

  initial begin
    forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////
  // one command handshake; a clock passes first so that cmdValid is never set twice at once
  task automatic issue(input op_t op, input logic [ADDR_W-1:0] a);
    @(negedge ref_clk);
    lastWait = 0;
    while (cmdReady !== 1'b1 && lastWait < 5000) begin
      @(negedge ref_clk);
      lastWait++;
    end
    cmdOp = op;
    cmdAddr = a;
    cmdData = 16'hC3C3;
    cmdValid = 1'b1;
    @(negedge ref_clk);
    cmdValid = 1'b0;
    lastWait = 0;
    while (rspValid !== 1'b1 && lastWait < 5000) begin
      @(negedge ref_clk);
      lastWait++;
    end
  endtask
  task automatic run(input op_t op, input logic [ADDR_W-1:0] a, input logic rf,
      input mode_t m);
    issue(op, a);
    `CHK(rspValid, 1'b1)
    `CHK(rspRefused, rf)
    `CHK(deviceMode, m)
  endtask
  // polls until the toggle bit stops; mode stays busy until the answer that reports done
  task automatic poll_done(input logic [ADDR_W-1:0] a, input mode_t busy, input mode_t m);
    int k;
    k = 0;
    do begin
      issue(OP_POLL, a);
      `CHK(rspValid, 1'b1)
      `CHK(rspRefused, 1'b0)
      `CHK(deviceMode, (rspOpDone === 1'b1) ? m : busy)
      k++;
    end while (rspOpDone !== 1'b1 && k < 20);
    `CHK(rspOpDone, 1'b1)
    `CHK(deviceMode, m)
  endtask
  task automatic report_and_stop;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    `CHK(deviceMode, M_READY)
    `CHK({ceN, oeN, weN, dqDrvN, protectAccelHigh, cmdReady}, 6'h3D)
  endtask
  task automatic t_stray;
    run(OP_SUSPEND, 19'h00000, 1'b1, M_READY);
    run(OP_RESUME, 19'h00000, 1'b1, M_READY);
  endtask
  task automatic t_erase;
    run(OP_SECTOR_ERASE, 19'h10000, 1'b0, M_ERASING);
    run(OP_SUSPEND, 19'h00000, 1'b0, M_ERASE_SUSP);
    `CHK(lastWait >= ERASE_SUSP_CYC, 1'b1)
    run(OP_READ, 19'h10004, 1'b1, M_ERASE_SUSP);
    run(OP_READ, 19'h20004, 1'b0, M_ERASE_SUSP);
    `CHK(rspData, 16'h5A5E)
    run(OP_ID_ENTER, 19'h00000, 1'b0, M_ERASE_SUSP);
    run(OP_RESET, 19'h00000, 1'b0, M_ERASE_SUSP);
    run(OP_PROGRAM, 19'h20010, 1'b0, M_PROG_IN_ESUSP);
    run(OP_SUSPEND, 19'h00000, 1'b0, M_PROG_SUSP_ES);
    `CHK(lastWait >= PROG_SUSP_CYC, 1'b1)
    run(OP_READ, 19'h20004, 1'b1, M_PROG_SUSP_ES);
    run(OP_ID_ENTER, 19'h20000, 1'b0, M_PROG_SUSP_ES);
    run(OP_RESET, 19'h00000, 1'b0, M_PROG_SUSP_ES);
    run(OP_RESUME, 19'h00000, 1'b0, M_PROG_IN_ESUSP);
    run(OP_RESUME, 19'h00000, 1'b1, M_PROG_IN_ESUSP);
    poll_done(19'h20010, M_PROG_IN_ESUSP, M_ERASE_SUSP);
    run(OP_RESUME, 19'h10000, 1'b0, M_ERASING);
    run(OP_RESUME, 19'h10000, 1'b1, M_ERASING);
    run(OP_SUSPEND, 19'h00000, 1'b0, M_ERASE_SUSP);
    run(OP_RESUME, 19'h10000, 1'b0, M_ERASING);
    poll_done(19'h10000, M_ERASING, M_READY);
  endtask
  task automatic t_chip;
    run(OP_CHIP_ERASE, 19'h00000, 1'b0, M_CHIP_ERASE);
    run(OP_SUSPEND, 19'h00000, 1'b1, M_CHIP_ERASE);
    poll_done(19'h00000, M_CHIP_ERASE, M_READY);
  endtask
  task automatic t_accel;
    run(OP_ACCEL_ON, 19'h00000, 1'b1, M_READY);
    `CHK(protectAccelHigh, 1'b0)
    sectorUnlocked = 1'b1;
    run(OP_ACCEL_ON, 19'h00000, 1'b0, M_READY);
    `CHK(protectAccelHigh, 1'b1)
    repeat (2) begin
      run(OP_PROGRAM, 19'h30020, 1'b0, M_PROG);
      poll_done(19'h30020, M_PROG, M_READY);
    end
    run(OP_PROGRAM, 19'h30020, 1'b1, M_READY);
    run(OP_ACCEL_OFF, 19'h00000, 1'b0, M_READY);
    `CHK(protectAccelHigh, 1'b0)
    run(OP_BYPASS_EXIT, 19'h00000, 1'b0, M_READY);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (6) @(negedge ref_clk);
    arst_n = 1'b1;
    @(negedge ref_clk);
    t_reset();
    t_stray();
    t_erase();
    t_chip();
    t_accel();
    report_and_stop();
  end
  // about 8k cycles expected; 50k cycles allowed
  initial begin
    #400_000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
